// *** design/serial_cfg_pkg.sv ***
// Functional notes
// - sixteen 32-bit latches behind one three-wire port
// - port ignores everything while chip enable low
// - data MSB first, captured on clock rise
// - strobe rise copies shift register into one latch
// - low four bits pick the destination latch
// - readback starts: latch 7 written, bit 8 set
// - readback after latching; strobe held high throughout
// - device shifts readback word out MSB first
// - host discards first bit after the latch
// - eighteen clocks per readback, then strobe low
// - frequency error: signed 16 bits, FSK only
// - value times demod clock over 2^18 is IF
// - strength: level 6:0, filter 8:7, LNA 10:9
// - host locks gain loop before readback with AFC
// - lock modes: sync-hold, sync-count, immediate, release
// - battery, aux ADC, temperature: 7 bits in 6:0
// - revision: product code 15:4, revision 3:0
// - filter calibration: 8 bits, upper byte zero
// - host may trim filter with readback minus 128
package serial_cfg_pkg;
  // ==========================================
  // serial word layout
  localparam int WORD_W = 32;
  localparam int NUM_LATCHES = 16;
  localparam int ADDR_W = 4;
  localparam int RB_BITS = 16;
  localparam int RB_CLOCKS = 18;
  localparam logic [3:0] RB_SETUP_ADDR = 4'h7;
  localparam int RB_SELECT_BIT = 8;
  localparam int RB_CODE_LSB = 4;
  localparam int RB_CODE_W = 3;
  localparam logic [3:0] LOCK_REG_ADDR = 4'hC;
  localparam int LOCK_LSB = 4;
  localparam int FILTER_ADJ_LSB = 14;
  localparam logic [7:0] FILTER_CAL_MID = 8'h80;
  // ==========================================
  // readback selection codes
  localparam logic [2:0] RB_BATTERY = 3'h0;
  localparam logic [2:0] RB_TEMP = 3'h1;
  localparam logic [2:0] RB_AUX_ADC = 3'h2;
  localparam logic [2:0] RB_STRENGTH = 3'h3;
  localparam logic [2:0] RB_FREQ_ERR = 3'h4;
  localparam logic [2:0] RB_REVISION = 3'h5;
  localparam logic [2:0] RB_FILTER_CAL = 3'h6;
  // ==========================================
  // gain lock modes
  localparam logic [1:0] LOCK_RELEASE = 2'h0;
  localparam logic [1:0] LOCK_SYNC_HOLD = 2'h1;
  localparam logic [1:0] LOCK_SYNC_COUNT = 2'h2;
  localparam logic [1:0] LOCK_NOW = 2'h3;
  // ==========================================
  // timing at the 10 MHz system clock
  localparam int CLK_FREQ_HZ = 10000000;
  localparam int CE_SETTLE_US = 100;
  localparam int CE_SETTLE_CYCLES = CE_SETTLE_US * (CLK_FREQ_HZ / 1000000);
  localparam int SCLK_HALF_CYCLES = 8;
  // ==========================================
  // host controller register offsets
  localparam logic [7:0] OFS_TX_WORD = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RB_DATA = 8'h0C;
  localparam int CTL_START = 0;
  localparam int CTL_READBACK = 1;
  localparam int CTL_CHIP_EN = 2;
  localparam int STS_BUSY = 0;
  localparam int STS_DONE = 1;
  localparam int STS_SETTLED = 2;
endpackage

// *** design/serial_port_if.sv ***
`timescale 1ns/100ps
// ==========================================
// three-wire port plus readback pin
interface serial_port_if;
  logic chip_enable; // device enable, high active
  logic serial_clock; // host-made shift clock
  logic serial_write_data; // write data, MSB first
  logic serial_latch_strobe; // latch strobe
  logic serial_read_data_o; // device readback drive value
  logic serial_read_data_oe; // high while device drives
  logic serial_read_data; // resolved pin level
  // pin resolution; no pull here, so a released pin shows the inverse level
  assign serial_read_data = serial_read_data_oe ? serial_read_data_o : ~serial_read_data_o;
  modport dev (
    input chip_enable,
    input serial_clock,
    input serial_write_data,
    input serial_latch_strobe,
    output serial_read_data_o,
    output serial_read_data_oe
  );
  modport host (
    output chip_enable,
    output serial_clock,
    output serial_write_data,
    output serial_latch_strobe,
    input serial_read_data
  );
endinterface

// *** design/cfg_port_device.sv ***
`timescale 1ns/100ps
// ==========================================
// device end: shift register, latches, readback
module cfg_port_device #(
  parameter logic [11:0] PRODUCT_CODE = 12'h345, // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h1 // arbitrary value
) (
  input wire logic CLK,
  input wire logic RST_N,
  serial_port_if.dev PORT,
  input wire logic [serial_cfg_pkg::RB_BITS-1:0] FREQ_ERROR,
  input wire logic FREQ_ERROR_VALID,
  input wire logic [6:0] STRENGTH_LEVEL,
  input wire logic [1:0] FILTER_GAIN,
  input wire logic [1:0] LNA_GAIN,
  input wire logic [6:0] BATTERY_LEVEL,
  input wire logic [6:0] AUX_ADC_LEVEL,
  input wire logic [6:0] TEMP_LEVEL,
  input wire logic [7:0] FILTER_CAL,
  input wire logic SYNC_FOUND,
  input wire logic LOCK_SPAN_DONE,
  output logic [serial_cfg_pkg::NUM_LATCHES*serial_cfg_pkg::WORD_W-1:0] CONFIG_WORDS,
  output logic LATCH_PULSE,
  output logic [serial_cfg_pkg::ADDR_W-1:0] LATCH_ADDR,
  output logic GAIN_LOCK
);
  import serial_cfg_pkg::*;

  // ==========================================
  // pin synchronisers
  // bit order: strobe, data, clock, enable
  logic [3:0] pin_sync1_reg; // first stage, read only by second
  logic [3:0] pin_sync2_reg; // stable copies
  logic clk_prev_reg; // previous clock level
  logic strobe_prev_reg; // previous strobe level
  logic ce_on; // enable seen
  logic clk_rise; // qualified clock edge
  logic strobe_rise; // qualified strobe edge
  logic strobe_level; // strobe still high

  // two stages before any logic looks at a pin
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pin_sync1_reg <= 4'h0;
      pin_sync2_reg <= 4'h0;
    end else begin
      pin_sync1_reg <= {PORT.serial_latch_strobe, PORT.serial_write_data,
                        PORT.serial_clock, PORT.chip_enable};
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // edge history
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      clk_prev_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= pin_sync2_reg[1];
      strobe_prev_reg <= pin_sync2_reg[3];
    end
  end

  // all edges gated by enable, so a dead port sees nothing
  assign ce_on = pin_sync2_reg[0];
  assign clk_rise = ce_on & pin_sync2_reg[1] & ~clk_prev_reg;
  assign strobe_rise = ce_on & pin_sync2_reg[3] & ~strobe_prev_reg;
  assign strobe_level = pin_sync2_reg[3];

  // ==========================================
  // write path
  logic [WORD_W-1:0] shift_reg; // incoming word
  logic [WORD_W-1:0] latch_mem [NUM_LATCHES]; // holding latches
  logic latch_pulse_reg; // one-cycle latch event
  logic [ADDR_W-1:0] latch_addr_reg; // last latch written

  // one bit per clock rise, oldest bit ends up in bit 31
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      shift_reg <= '0;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], pin_sync2_reg[2]};
    end
  end

  // whole word copied on the strobe edge, address from the low nibble
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_LATCHES; i++) begin
        latch_mem[i] <= '0;
      end
    end else if (strobe_rise) begin
      latch_mem[shift_reg[ADDR_W-1:0]] <= shift_reg;
    end
  end

  // latch event report
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_pulse_reg <= 1'b0;
      latch_addr_reg <= '0;
    end else begin
      latch_pulse_reg <= strobe_rise;
      if (strobe_rise) begin
        latch_addr_reg <= shift_reg[ADDR_W-1:0];
      end
    end
  end

  // flatten latches for the rest of the chip
  generate
    for (genvar g = 0; g < NUM_LATCHES; g++) begin : g_flat
      assign CONFIG_WORDS[g*WORD_W +: WORD_W] = latch_mem[g];
    end
  endgenerate
  assign LATCH_PULSE = latch_pulse_reg;
  assign LATCH_ADDR = latch_addr_reg;

  // ==========================================
  // readback word selection
  function automatic logic [RB_BITS-1:0] pick_word(input logic [RB_CODE_W-1:0] code);
    logic [RB_BITS-1:0] w;
    w = '0;
    unique case (code)
      // signed, value*demod/2^18 is the IF; zero when not valid
      RB_FREQ_ERR: w = FREQ_ERROR_VALID ? FREQ_ERROR : '0;
      RB_STRENGTH: w = {5'h00, LNA_GAIN, FILTER_GAIN, STRENGTH_LEVEL};
      RB_BATTERY: w = {9'h000, BATTERY_LEVEL};
      RB_TEMP: w = {9'h000, TEMP_LEVEL};
      RB_AUX_ADC: w = {9'h000, AUX_ADC_LEVEL};
      RB_REVISION: w = {PRODUCT_CODE, REVISION_CODE};
      RB_FILTER_CAL: w = {8'h00, FILTER_CAL};
      default: w = '0; // unused code reads zero
    endcase
    return w;
  endfunction

  // ==========================================
  // readback shifter
  logic rb_active_reg; // readback in progress
  logic [4:0] rb_count_reg; // clock rises seen in readback
  logic [RB_BITS-1:0] rb_shift_reg; // word being sent
  logic rd_out_reg; // pin value
  logic rd_oe_reg; // pin drive enable
  logic rb_start; // setup word latched with select bit

  assign rb_start = strobe_rise && (shift_reg[ADDR_W-1:0] == RB_SETUP_ADDR)
                    && shift_reg[RB_SELECT_BIT];

  // first rise drives a throwaway bit, then 16 bits, then release
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rb_active_reg <= 1'b0;
      rb_count_reg <= 5'h00;
      rb_shift_reg <= '0;
      rd_out_reg <= 1'b0;
      rd_oe_reg <= 1'b0;
    end else if (rb_start) begin
      // parallel load at the latch edge
      rb_active_reg <= 1'b1;
      rb_count_reg <= 5'h00;
      rb_shift_reg <= pick_word(shift_reg[RB_CODE_LSB +: RB_CODE_W]);
      rd_oe_reg <= 1'b0;
    end else if (!ce_on || (rb_active_reg && !strobe_level)) begin
      // enable lost or strobe dropped early: let the pin float
      rb_active_reg <= 1'b0;
      rd_oe_reg <= 1'b0;
    end else if (rb_active_reg && clk_rise) begin
      rb_count_reg <= rb_count_reg + 5'h01;
      if (rb_count_reg == 5'h00) begin
        // throwaway bit, host ignores it
        rd_oe_reg <= 1'b1;
        rd_out_reg <= 1'b0;
      end else if (rb_count_reg <= 5'(RB_BITS)) begin
        rd_out_reg <= rb_shift_reg[RB_BITS-1];
        rb_shift_reg <= {rb_shift_reg[RB_BITS-2:0], 1'b0};
      end else begin
        // eighteenth rise returns the pin to float
        rd_oe_reg <= 1'b0;
        rb_active_reg <= 1'b0;
      end
    end
  end

  assign PORT.serial_read_data_o = rd_out_reg;
  assign PORT.serial_read_data_oe = rd_oe_reg;

  // ==========================================
  // gain / threshold lock
  logic lock_reg; // envelope, AFC and AGC frozen
  logic [1:0] lock_mode; // current mode field

  assign lock_mode = latch_mem[LOCK_REG_ADDR][LOCK_LSB +: 2];

  // mode change only takes hold on the next cycle after the latch
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lock_reg <= 1'b0;
    end else begin
      unique case (lock_mode)
        LOCK_RELEASE: lock_reg <= 1'b0;
        LOCK_NOW: lock_reg <= 1'b1;
        LOCK_SYNC_HOLD: begin
          if (SYNC_FOUND) begin
            lock_reg <= 1'b1;
          end
        end
        LOCK_SYNC_COUNT: begin
          // byte count elapsed releases, a new sync word relocks
          if (SYNC_FOUND) begin
            lock_reg <= 1'b1;
          end else if (LOCK_SPAN_DONE) begin
            lock_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  assign GAIN_LOCK = lock_reg;
endmodule

// *** design/cfg_port_host.sv ***
`timescale 1ns/100ps
// ==========================================
// host end: AHB-Lite registers driving the serial port
module cfg_port_host #(
  parameter int SCLK_HALF = serial_cfg_pkg::SCLK_HALF_CYCLES // cycles per clock half
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  serial_port_if.host PORT
);
  import serial_cfg_pkg::*;

  // ==========================================
  // bus slave, zero wait states
  logic wr_pend_reg; // write data phase pending
  logic [7:0] wr_addr_reg; // write offset
  logic [31:0] hrdata_reg; // read data for data phase
  logic [WORD_W-1:0] tx_word_reg; // word to send
  logic ce_reg; // chip enable drive
  logic rb_req_reg; // next transfer is a readback
  logic [RB_BITS-1:0] rb_data_reg; // last readback word
  logic done_reg; // sticky transfer done
  logic [10:0] settle_reg; // enable settle countdown
  logic busy; // engine running
  logic settled; // enable long enough
  logic addr_ok; // valid address phase
  logic start_req; // start accepted

  assign addr_ok = HSEL & HREADY & HTRANS[1];
  assign settled = (settle_reg == 11'h000);

  // latch the address phase; read data prepared now
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_ok & HWRITE;
      wr_addr_reg <= HADDR[7:0];
      if (addr_ok && !HWRITE) begin
        unique case (HADDR[7:0])
          OFS_TX_WORD: hrdata_reg <= tx_word_reg;
          OFS_CONTROL: hrdata_reg <= {29'h0, ce_reg, rb_req_reg, 1'b0};
          OFS_STATUS: hrdata_reg <= {29'h0, settled, done_reg, busy};
          OFS_RB_DATA: hrdata_reg <= {16'h0000, rb_data_reg};
          default: hrdata_reg <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // start ignored while busy or before the enable has settled
  assign start_req = wr_pend_reg && (wr_addr_reg == OFS_CONTROL)
                     && HWDATA[CTL_START] && !busy && settled && ce_reg;

  // software-written registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_word_reg <= '0;
      ce_reg <= 1'b0;
      rb_req_reg <= 1'b0;
    end else if (wr_pend_reg && !busy) begin
      if (wr_addr_reg == OFS_TX_WORD) begin
        tx_word_reg <= HWDATA;
      end else if (wr_addr_reg == OFS_CONTROL) begin
        ce_reg <= HWDATA[CTL_CHIP_EN];
        rb_req_reg <= HWDATA[CTL_READBACK];
      end
    end
  end

  // enable must stand before the first write
  always_ff @(posedge CLK) begin
    if (!RST_N || !ce_reg) begin
      settle_reg <= 11'(CE_SETTLE_CYCLES);
    end else if (!settled) begin
      settle_reg <= settle_reg - 11'h001;
    end
  end

  // ==========================================
  // serial engine
  typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_LATCH, ST_READ, ST_RELEASE} eng_state_t;
  eng_state_t state_reg; // engine state
  logic [7:0] div_reg; // half-period counter
  logic tick; // end of a half period
  logic sclk_reg; // serial clock drive
  logic wbit_reg; // data drive
  logic stb_reg; // strobe drive
  logic [WORD_W-1:0] out_shift_reg; // word going out
  logic [5:0] bit_reg; // bits or read clocks issued
  logic [1:0] rd_sync_reg; // readback pin synchroniser

  assign busy = (state_reg != ST_IDLE);
  assign tick = (div_reg == 8'(SCLK_HALF - 1));

  // half-period timer, runs only while busy
  always_ff @(posedge CLK) begin
    if (!RST_N || !busy || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // two flops on the readback pin
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_sync_reg <= 2'h0;
    end else begin
      rd_sync_reg <= {rd_sync_reg[0], PORT.serial_read_data};
    end
  end

  // data changes on falling clock, device takes it on the rise
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      sclk_reg <= 1'b0;
      wbit_reg <= 1'b0;
      stb_reg <= 1'b0;
      out_shift_reg <= '0;
      bit_reg <= 6'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_SHIFT;
            wbit_reg <= tx_word_reg[WORD_W-1];
            out_shift_reg <= {tx_word_reg[WORD_W-2:0], 1'b0};
            bit_reg <= 6'h00;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              // falling edge: next bit, or finish the word
              bit_reg <= bit_reg + 6'h01;
              wbit_reg <= out_shift_reg[WORD_W-1];
              out_shift_reg <= {out_shift_reg[WORD_W-2:0], 1'b0};
              if (bit_reg == 6'(WORD_W - 1)) begin
                state_reg <= ST_LATCH;
              end
            end
          end
        end
        ST_LATCH: begin
          stb_reg <= 1'b1;
          if (tick) begin
            bit_reg <= 6'h00;
            // readback keeps the strobe up, a plain write drops it
            state_reg <= rb_req_reg ? ST_READ : ST_RELEASE;
          end
        end
        ST_READ: begin
          if (tick) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
              if (bit_reg == 6'(RB_CLOCKS)) begin
                state_reg <= ST_RELEASE;
              end
            end else begin
              bit_reg <= bit_reg + 6'h01;
            end
          end
        end
        ST_RELEASE: begin
          stb_reg <= 1'b0;
          if (tick) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // sample just before each rise; skip the throwaway bit
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rb_data_reg <= '0;
    end else if (state_reg == ST_READ && tick && !sclk_reg
                 && bit_reg >= 6'h02 && bit_reg <= 6'(RB_BITS + 1)) begin
      rb_data_reg <= {rb_data_reg[RB_BITS-2:0], rd_sync_reg[1]};
    end
  end

  // done is sticky until the next start
  always_ff @(posedge CLK) begin
    if (!RST_N || start_req) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_RELEASE && tick) begin
      done_reg <= 1'b1;
    end
  end

  assign PORT.chip_enable = ce_reg;
  assign PORT.serial_clock = sclk_reg;
  assign PORT.serial_write_data = wbit_reg;
  assign PORT.serial_latch_strobe = stb_reg;
endmodule

// *** bench/three_wire_config_readback_props.sv ***
`timescale 1ns/100ps
// ==========================================
// wire-level checks between the two ends
module three_wire_config_readback_props #(
  parameter int SCLK_HALF = 8 // clocks per serial half period
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic chip_enable,
  input wire logic serial_clock,
  input wire logic serial_write_data,
  input wire logic serial_latch_strobe,
  input wire logic serial_read_data_o,
  input wire logic serial_read_data_oe
);
  int oe_cnt_reg; // cycles the readback drive has been on

  // ==========================================
  // drive length counter, cleared whenever the pin floats
  always_ff @(posedge CLK) begin
    if (!RST_N || !serial_read_data_oe) begin
      oe_cnt_reg <= 0;
    end else begin
      oe_cnt_reg <= oe_cnt_reg + 1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================
  // assertions
  idle_when_off_a: assert property (
    !chip_enable |-> !serial_clock && !serial_latch_strobe)
    else $error("serial pins active with chip enable low");
  float_when_off_a: assert property (
    !chip_enable [*4] |-> !serial_read_data_oe)
    else $error("readback drive kept with chip enable low");
  data_stable_high_a: assert property (
    serial_clock |-> $stable(serial_write_data))
    else $error("write data moved while serial clock high");
  half_period_a: assert property (
    $fell(serial_clock) |-> $past(serial_clock, SCLK_HALF) && !$past(serial_clock, SCLK_HALF + 1))
    else $error("serial clock high phase has wrong length");
  strobe_clock_low_a: assert property (
    $rose(serial_latch_strobe) |-> !serial_clock)
    else $error("strobe rose while serial clock high");
  read_after_latch_a: assert property (
    $rose(serial_read_data_oe) |-> serial_latch_strobe && serial_clock)
    else $error("readback drive began outside a strobed clock");
  read_moves_on_rise_a: assert property (
    serial_read_data_oe && $changed(serial_read_data_o) |-> serial_clock)
    else $error("readback bit changed during clock low");
  strobe_held_a: assert property (
    serial_read_data_oe |-> serial_latch_strobe)
    else $error("strobe dropped while readback driven");
  read_span_a: assert property (
    $fell(serial_read_data_oe) && serial_latch_strobe |-> oe_cnt_reg == 34 * SCLK_HALF)
    else $error("readback drive span is not seventeen clocks");

  // ==========================================
  // coverage of the main transfers
  cover property ($rose(serial_read_data_oe));
  cover property ($fell(serial_read_data_oe) && serial_latch_strobe);
  cover property ($rose(serial_latch_strobe) && !serial_read_data_oe);
endmodule

// *** bench/three_wire_config_readback_tb.sv ***
`timescale 1ns/100ps
// ==========================================
// host and device joined, driven over the bus
module three_wire_config_readback_tb;
  import serial_cfg_pkg::*;
  localparam int HALF = 8; // serial half period, near the minimum of 5 is not needed
  localparam logic [11:0] PCODE = 12'h5A3; // arbitrary value
  localparam logic [3:0] RCODE = 4'h2; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [15:0] freq_err = 16'h0;
  logic fe_valid = 1'b0;
  logic [6:0] strength = 7'h0, battery = 7'h0, aux = 7'h0, temp = 7'h0;
  logic [1:0] fgain = 2'h0, lgain = 2'h0;
  logic [7:0] fcal = 8'h0;
  logic sync = 1'b0, span = 1'b0; // gain lock events
  logic [NUM_LATCHES*WORD_W-1:0] cfg_words;
  logic [ADDR_W-1:0] latch_addr;
  logic gain_lock;
  logic latch_pulse; // one-cycle latch event
  int pulses = 0; // latch events seen
  logic [31:0] rd; // last bus read
  logic [31:0] w;
  logic [1:0] modes [5] = '{LOCK_NOW, LOCK_RELEASE, LOCK_SYNC_HOLD, LOCK_RELEASE, LOCK_SYNC_COUNT};
  int mismatches = 0;
  int compares = 0;
  int n;
  serial_port_if serial_port_if_inst ();
  always #50 clk = ~clk;
  cfg_port_host #(.SCLK_HALF(HALF)) cfg_port_host_inst (.CLK(clk), .RST_N(rst_n),
    .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(),
    .PORT(serial_port_if_inst.host));
  cfg_port_device #(.PRODUCT_CODE(PCODE), .REVISION_CODE(RCODE)) cfg_port_device_inst (
    .CLK(clk), .RST_N(rst_n), .PORT(serial_port_if_inst.dev), .FREQ_ERROR(freq_err),
    .FREQ_ERROR_VALID(fe_valid), .STRENGTH_LEVEL(strength), .FILTER_GAIN(fgain),
    .LNA_GAIN(lgain), .BATTERY_LEVEL(battery), .AUX_ADC_LEVEL(aux), .TEMP_LEVEL(temp),
    .FILTER_CAL(fcal), .SYNC_FOUND(sync), .LOCK_SPAN_DONE(span), .CONFIG_WORDS(cfg_words),
    .LATCH_PULSE(latch_pulse), .LATCH_ADDR(latch_addr), .GAIN_LOCK(gain_lock));
  three_wire_config_readback_props #(.SCLK_HALF(HALF)) three_wire_config_readback_props_inst (
    .CLK(clk), .RST_N(rst_n), .chip_enable(serial_port_if_inst.chip_enable),
    .serial_clock(serial_port_if_inst.serial_clock),
    .serial_write_data(serial_port_if_inst.serial_write_data),
    .serial_latch_strobe(serial_port_if_inst.serial_latch_strobe),
    .serial_read_data_o(serial_port_if_inst.serial_read_data_o),
    .serial_read_data_oe(serial_port_if_inst.serial_read_data_oe));

  // count latch pulses, one per strobed word expected
  always @(posedge clk) begin
    if (latch_pulse) begin
      pulses <= pulses + 1;
    end
  end

  // ==========================================
  // comparison and verdict
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================
  // one single bus transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // load a word, start with chip enable kept on, poll until idle
  task frame(input logic [31:0] word, input logic rb);
    int k;
    bus(1'b1, OFS_TX_WORD, word);
    bus(1'b1, OFS_CONTROL, {29'h0, 1'b1, rb, 1'b1});
    k = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while ((rd[STS_DONE] !== 1'b1 || rd[STS_BUSY] !== 1'b0) && k < 3000);
    check("done", {31'h0, rd[STS_DONE]}, 32'h1);
  endtask
  // expected readback word for a selection code
  function automatic logic [15:0] rb_exp(input logic [2:0] c);
    case (c)
      RB_BATTERY: rb_exp = {9'h0, battery};
      RB_TEMP: rb_exp = {9'h0, temp};
      RB_AUX_ADC: rb_exp = {9'h0, aux};
      RB_STRENGTH: rb_exp = {5'h0, lgain, fgain, strength};
      RB_FREQ_ERR: rb_exp = fe_valid ? freq_err : 16'h0;
      RB_REVISION: rb_exp = {PCODE, RCODE};
      RB_FILTER_CAL: rb_exp = {8'h00, fcal};
      default: rb_exp = 16'h0;
    endcase
  endfunction
  // lock mode write, then a sync event, then an end-of-span event
  task lock_step(input logic [1:0] m);
    logic [2:0] e;
    e = (m == LOCK_NOW) ? 3'h7 : (m == LOCK_SYNC_HOLD) ? 3'h3 :
        (m == LOCK_SYNC_COUNT) ? 3'h2 : 3'h0;
    frame({26'h0, m, LOCK_REG_ADDR}, 1'b0);
    check("lock", {31'h0, gain_lock}, {31'h0, e[2]});
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    repeat (3) @(posedge clk);
    check("lock sync", {31'h0, gain_lock}, {31'h0, e[1]});
    span <= 1'b1;
    @(posedge clk);
    span <= 1'b0;
    repeat (3) @(posedge clk);
    check("lock span", {31'h0, gain_lock}, {31'h0, e[0]});
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'hEE9B7DB9));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("status reset", rd, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h4);
    bus(1'b0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'h4);
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[STS_SETTLED] !== 1'b1 && n < 2000);
    $display("test registers done");
    // addresses 0,3,6,9,12,15,2,5: latch 7 kept out to avoid a stray readback
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'hFFFFFFF0 : $urandom;
      w[3:0] = 4'(i * 3);
      frame(w, 1'b0);
      check("latch", cfg_words[w[3:0]*32+:32], w);
      check("latch addr", {28'h0, latch_addr}, {28'h0, w[3:0]});
    end
    check("pulses", pulses, 32'h8);
    $display("test writes done");
    for (int i = 0; i < 10; i++) begin
      freq_err <= 16'($urandom);
      fe_valid <= 1'($urandom);
      strength <= 7'($urandom);
      fgain <= 2'($urandom);
      lgain <= 2'($urandom);
      battery <= 7'($urandom);
      aux <= 7'($urandom);
      temp <= 7'($urandom);
      fcal <= 8'($urandom);
      @(posedge clk);
      frame({23'h0, 1'b1, 1'b0, 3'(i), RB_SETUP_ADDR}, 1'b1);
      bus(1'b0, OFS_RB_DATA, 32'h0);
      check("readback", rd, {16'h0, rb_exp(3'(i))});
      // filter trim from the calibration readback into latch 5
      if (i == 6) begin
        w = {12'h0, 6'(fcal - FILTER_CAL_MID), 10'h0, 4'h5};
        frame({w[31:20], 6'(rd[7:0] - FILTER_CAL_MID), w[13:0]}, 1'b0);
        check("trim", cfg_words[5*32+:32], w);
      end
    end
    $display("test readbacks done");
    foreach (modes[j]) lock_step(modes[j]);
    $display("test lock modes done");
    tally_and_finish();
  end

  // ==========================================
  // watchdog, about five times the expected run
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    $display("FAIL watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule
